/* verilog/timer0_pkg.sv */
// Package for the shared-prescaler timer: offsets, fields, resets, timing.
// Assumes a single 100 MHz system clock and a plain register port.
`default_nettype none
package timer0_pkg;
  // Register offsets (printed offsets are byte addresses on this port)
  localparam logic [7:0] TIMER_COUNT_OFS  = 8'h01;
  localparam logic [7:0] INTR_CTRL_OFS    = 8'h0b;
  localparam logic [7:0] OPTION_CFG_OFS   = 8'h81;
  localparam logic [7:0] INTR_STATUS_OFS  = 8'h90;
  localparam logic [7:0] INTR_MASK_OFS    = 8'h91;
  // Option register fields
  localparam int SRC_SEL_BIT   = 5;
  localparam int EDGE_SEL_BIT  = 4;
  localparam int OWNER_SEL_BIT = 3;
  localparam int RATIO_MSB     = 2;
  // Interrupt control field: overflow flag
  localparam int OVF_FLAG_BIT  = 2;
  // Reset values
  localparam logic [7:0] OPTION_RESET = 8'hff;
  localparam logic [7:0] INTR_RESET   = 8'h00;
  localparam logic [7:0] COUNT_RESET  = 8'h00;
  localparam logic [1:0] STAT_RESET   = 2'h0;
  // Interrupt status bits
  localparam int EV_OVF_BIT    = 0;
  localparam int EV_WDT_BIT    = 1;
  // Instruction cycle is four system clocks (phases Q1..Q4)
  localparam int PHASES        = 4;
  // Increments held off after a count write, in instruction cycles
  localparam int INHIBIT_CYC   = 2;
  localparam logic [3:0] INHIBIT_CLKS = 4'(INHIBIT_CYC * PHASES);
endpackage
`default_nettype wire

/* verilog/prescale_counter.sv */
// Eight-bit prescaler counter with a selectable output tap.
// Assumes the owner supplies a one-cycle advance pulse and a clear.
`default_nettype none
module prescale_counter #(
  parameter int WIDTH = 8
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire logic       i_clear,     // Synchronous clear, wins over advance
  input  wire logic       i_advance,   // One-cycle advance pulse
  input  wire logic [3:0] i_tap,       // Tap index, 0 means bypass
  output logic            o_tap_pulse  // Pulse when selected tap wraps
);
  logic [WIDTH-1:0] count_r;   // Hidden count, no software path
  logic [WIDTH-1:0] count_nxt; // Value after this advance
  logic             wrap;      // Selected tap rolls over

  assign count_nxt = count_r + WIDTH'(1);

  // Tap wraps when every bit below it is set before the advance
  always_comb begin
    wrap = 1'b0;
    if (i_tap == 4'h0) begin
      wrap = i_advance;
    end else begin
      wrap = i_advance &&
             ((count_r & ((WIDTH'(1) << i_tap[2:0]) - WIDTH'(1)))
              == ((WIDTH'(1) << i_tap[2:0]) - WIDTH'(1))) &&
             (i_tap <= 4'(WIDTH)) &&
             ((i_tap == 4'(WIDTH)) ? (&count_r) : 1'b1);
    end
  end

  // Counter: cleared on demand, otherwise advances
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || i_clear) begin
      count_r <= '0;
    end else if (i_advance) begin
      count_r <= count_nxt;
    end
  end

  assign o_tap_pulse = wrap;
endmodule
`default_nettype wire

/* verilog/timer0_shared_prescaler.sv */
// Eight-bit timer/counter with one prescaler shared with a watchdog.
// Assumes the count pin is synchronous to i_sys_clk and the watchdog
// lives outside; this block feeds it ticks and clear requests.
//
// Strobed register access was chosen for this implementation.
`default_nettype none
module timer0_shared_prescaler #(
  parameter int PRESCALE_W = 8
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire logic [7:0] i_addr,            // Register byte address
  input  wire logic [7:0] i_wdata,           // Write data
  input  wire logic       i_wr,              // Write strobe
  input  wire logic       i_rd,              // Read strobe
  output logic      [7:0] o_rdata,           // Read data, cycle after i_rd
  input  wire logic       i_timer_ext_count_pin, // External count input
  input  wire logic       i_watchdog_clear_instr, // Watchdog-clear pulse
  input  wire logic       i_watchdog_base_tick,   // Watchdog oscillator tick
  output logic            o_watchdog_tick,   // Scaled tick to watchdog
  output logic            o_watchdog_clear,  // Clears watchdog counter
  output logic            o_irq              // Level interrupt
);
  logic [7:0] timer_count_reg;        // Count register
  logic [7:0] interrupt_control_reg;  // Interrupt control register
  logic [7:0] option_cfg_r;           // Option configuration
  logic [1:0] intr_status_r;          // Sticky event bits
  logic [1:0] intr_mask_r;            // Event masks
  // Timing state. The phase counter stands in for the four internal
  // phase clocks; everything else runs on every system clock edge.
  logic [1:0] phase_r;                // Q1..Q4 phase counter
  logic       pin_sync_r;             // Latest Q2 or Q4 sample
  logic       pin_prev_r;             // Previous synchronised level
  logic [3:0] inhibit_r;              // Increment hold-off counter
  logic [7:0] rdata_r;                // Registered read data

  // Decoded fields and strobes. All of these are combinational and are
  // derived from the registers above, the prescaler output or the module inputs.
  logic       count_src_sel;
  logic       count_edge_sel;
  logic       prescaler_owner_sel;
  logic [2:0] prescale_ratio_sel;
  logic       wr_count;
  logic       wr_intr;
  logic       wr_status;
  logic       instr_tick;
  logic       pin_level;
  logic       pin_edge;
  logic       timer_src;
  logic       pre_advance;
  logic       pre_clear;
  logic [3:0] pre_tap;
  logic       pre_out;
  logic       timer_inc;
  logic       wrap;
  logic       ovf_event;

  assign count_src_sel       = option_cfg_r[timer0_pkg::SRC_SEL_BIT];
  assign count_edge_sel      = option_cfg_r[timer0_pkg::EDGE_SEL_BIT];
  assign prescaler_owner_sel = option_cfg_r[timer0_pkg::OWNER_SEL_BIT];
  assign prescale_ratio_sel  = option_cfg_r[timer0_pkg::RATIO_MSB:0];

  // Write decodes
  assign wr_count  = i_wr && (i_addr == timer0_pkg::TIMER_COUNT_OFS);
  assign wr_intr   = i_wr && (i_addr == timer0_pkg::INTR_CTRL_OFS);
  assign wr_status = i_wr && (i_addr == timer0_pkg::INTR_STATUS_OFS);

  // Instruction cycle phase, Q1 at 0 through Q4 at 3.
  // Reset starts the cycle at Q1, so the first instruction tick comes
  // on the fourth edge after release. Nothing here realigns the phase
  // to the bus; software sees the phase only through timer behaviour.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      phase_r <= 2'h0;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end
  assign instr_tick = (phase_r == 2'h3);

  // Pin level, inverted for falling-edge counting
  assign pin_level = i_timer_ext_count_pin ^ count_edge_sel;

  // Sample on Q2 and Q4; the latest sample is the synchronised level.
  // Samples are two clocks apart, so a level that stands two clocks is
  // always seen, while a shorter pulse may fall between samples.
  // Reset sets both flops high: the reset option counts falling edges,
  // so an idle-low pin reads high and gives no false edge on release.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pin_sync_r <= 1'b1;
      pin_prev_r <= 1'b1;
    end else begin
      if (phase_r[0]) begin
        // Phase 1 is Q2, phase 3 is Q4
        pin_sync_r <= pin_level;
      end
      pin_prev_r <= pin_sync_r;
    end
  end
  // Rising edge of the synchronised level, one clock wide.
  // Changing the edge select flips the level and may give one edge;
  // software should clear the count after changing the option bits.
  assign pin_edge = pin_sync_r && !pin_prev_r;

  // Timer source: instruction cycle or pin edge
  assign timer_src = count_src_sel ? pin_edge : instr_tick;

  // Prescaler is driven by its owner only
  // Moving the owner does not clear the count; software must clear it
  // first, or the first scaled tick to the new owner comes early.
  assign pre_advance = prescaler_owner_sel ? i_watchdog_base_tick
                                           : timer_src;
  // Tap: timer gets ratio+1, watchdog gets ratio
  assign pre_tap = prescaler_owner_sel ? {1'b0, prescale_ratio_sel}
                                       : ({1'b0, prescale_ratio_sel}
                                          + 4'h1);
  // Clears touch the count only, never the option bits
  assign pre_clear = (!prescaler_owner_sel && wr_count) ||
                     (prescaler_owner_sel && i_watchdog_clear_instr);

  // Count is internal to the instance, no software path
  prescale_counter #(
    .WIDTH       (PRESCALE_W)
  ) u_prescaler (
    .i_sys_clk   (i_sys_clk),
    .i_rst       (i_rst),
    .i_clear     (pre_clear),
    .i_advance   (pre_advance),
    .i_tap       (pre_tap),
    .o_tap_pulse (pre_out)
  );

  // Non-owner runs unscaled; bypass passes source straight through
  assign timer_inc = prescaler_owner_sel ? timer_src : pre_out;
  assign o_watchdog_tick = prescaler_owner_sel ? pre_out
                                               : i_watchdog_base_tick;
  // Watchdog clear always reaches the watchdog counter
  assign o_watchdog_clear = i_watchdog_clear_instr;

  // Hold-off after a count write, counted in system clocks
  // Counting clocks rather than instruction ticks keeps the hold-off the
  // same length whatever phase the write lands in. A new write reloads
  // the counter, so back-to-back writes extend the hold-off.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      inhibit_r <= 4'h0;
    end else if (wr_count) begin
      inhibit_r <= timer0_pkg::INHIBIT_CLKS;
    end else if (inhibit_r != 4'h0) begin
      inhibit_r <= inhibit_r - 4'h1;
    end
  end

  // Count register: write wins, then gated increment
  // The prescaler still advances while increments are held off, so a
  // pin edge in that window may be absorbed by the prescaler.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      timer_count_reg <= timer0_pkg::COUNT_RESET;
    end else if (wr_count) begin
      timer_count_reg <= i_wdata;
    end else if (timer_inc && (inhibit_r == 4'h0)) begin
      timer_count_reg <= timer_count_reg + 8'h01;
    end
  end
  assign wrap = !wr_count && timer_inc && (inhibit_r == 4'h0) &&
                (timer_count_reg == 8'hff);
  assign ovf_event = wrap;

  // Interrupt control: overflow set beats software clear
  // Only the overflow bit has hardware behind it; the other bits are
  // plain storage so software can keep its enables here.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      interrupt_control_reg <= timer0_pkg::INTR_RESET;
    end else begin
      if (wr_intr) begin
        interrupt_control_reg <= i_wdata;
      end
      if (ovf_event) begin
        interrupt_control_reg[timer0_pkg::OVF_FLAG_BIT] <= 1'b1;
      end
    end
  end

  // Option register; untouched by prescaler clears
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      option_cfg_r <= timer0_pkg::OPTION_RESET;
    end else if (i_wr && (i_addr == timer0_pkg::OPTION_CFG_OFS)) begin
      option_cfg_r <= i_wdata;
    end
  end

  // Sticky status, write one to clear, event wins.
  // Losing an event that lands with the clear would hide an overflow
  // from software, so the event is ORed in after the clear mask.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      intr_status_r <= timer0_pkg::STAT_RESET;
    end else begin
      intr_status_r <= (intr_status_r & ~(wr_status ? i_wdata[1:0]
                                                    : 2'h0))
                       | {i_watchdog_clear_instr, ovf_event};
    end
  end

  // Interrupt mask
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      intr_mask_r <= 2'h0;
    end else if (i_wr && (i_addr == timer0_pkg::INTR_MASK_OFS)) begin
      intr_mask_r <= i_wdata[1:0];
    end
  end

  // Level interrupt from registers only, so it never glitches
  assign o_irq = |(intr_status_r & intr_mask_r);

  // Read mux; unmapped addresses read zero.
  // Data stand for one cycle only and are zero otherwise, so an OR-bus
  // of several slaves needs no extra gating.
  // The prescaler count has no address here at all.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rdata_r <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        timer0_pkg::TIMER_COUNT_OFS: rdata_r <= timer_count_reg;
        timer0_pkg::INTR_CTRL_OFS:   rdata_r <= interrupt_control_reg;
        timer0_pkg::OPTION_CFG_OFS:  rdata_r <= option_cfg_r;
        timer0_pkg::INTR_STATUS_OFS: rdata_r <= {6'h00, intr_status_r};
        timer0_pkg::INTR_MASK_OFS:   rdata_r <= {6'h00, intr_mask_r};
        default:                     rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end
  assign o_rdata = rdata_r;
endmodule
`default_nettype wire

/* sim/timer0_shared_prescaler_assertions.sv */
// Checker: bus and watchdog-path properties of the timer block.
// Assumes it is bound to the top module and sees only its ports.
`default_nettype none
module timer0_chk (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [7:0] o_rdata,
  input  wire logic       i_watchdog_clear_instr,
  input  wire logic       i_watchdog_base_tick,
  input  wire logic       o_watchdog_tick,
  input  wire logic       o_watchdog_clear
);
  logic [7:0] opt_r;  // Shadow of the option register
  // Tracks owner and ratio so the tick path can be judged
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) opt_r <= 8'hff;
    else if (i_wr && i_addr == 8'h81) opt_r <= i_wdata;
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  wdt_clr_a: assert property (
    o_watchdog_clear == i_watchdog_clear_instr) else $error("wdt clear");
  rd_idle_a: assert property (
    !i_rd |=> o_rdata == 8'h00) else $error("rdata not idle");
  unmapped_rd_a: assert property (
    i_rd && i_addr == 8'h02 |=> o_rdata == 8'h00) else $error("unmapped");
  opt_rd_a: assert property (
    i_rd && i_addr == 8'h81 |=> o_rdata == $past(opt_r))
    else $error("option readback");
  hold_off_a: assert property (
    i_wr && i_addr == 8'h01 ##1 i_rd && i_addr == 8'h01
    |=> o_rdata == $past(i_wdata, 2)) else $error("count moved");
  wdt_unscaled_a: assert property (
    !opt_r[3] |-> o_watchdog_tick == i_watchdog_base_tick)
    else $error("wdt scaled");
  wdt_one_a: assert property (
    opt_r[3] && opt_r[2:0] == 3'h0
    |-> o_watchdog_tick == i_watchdog_base_tick) else $error("wdt 1:1");
  tick_cause_a: assert property (
    o_watchdog_tick |-> i_watchdog_base_tick) else $error("stray tick");
endmodule
`default_nettype wire

/* sim/ext_count_source.sv */
// Partner: external clock source on the count pin, bursts of pulses.
// Assumes a burst is asked for only while the source is idle.
`default_nettype none
module ext_count_source (
  input  wire logic       i_sys_clk,
  input  wire logic       i_start,   // Begin a burst
  input  wire logic [7:0] i_pulses,  // Pulses in the burst
  input  wire logic [3:0] i_half,    // Clocks per level, two or more
  output logic            o_pin,     // Drives the count input
  output logic            o_busy     // Burst in progress
);
  logic [8:0] rem_r = 9'h0;  // Levels still to go
  logic [3:0] tmr_r = 4'h0;  // Clocks left at this level
  logic       pin_r = 1'b0;  // Idle low between bursts
  assign o_pin  = pin_r;
  assign o_busy = (rem_r != 9'h0);
  // Each level stands i_half clocks, one clock if i_half is under two
  always @(posedge i_sys_clk) begin
    if (!o_busy) begin
      if (i_start) begin
        rem_r <= {i_pulses, 1'b0};
        tmr_r <= i_half;
      end
    end else if (tmr_r <= 4'h1) begin
      pin_r <= ~pin_r;  // Even count of toggles, ends low
      rem_r <= rem_r - 9'h1;
      tmr_r <= i_half;
    end else begin
      tmr_r <= tmr_r - 4'h1;
    end
  end
endmodule
`default_nettype wire

/* sim/timer0_shared_prescaler_tb_top.sv */
// Bench top: drives registers, count pin and watchdog ticks.
// Assumes every design input is sampled on the rising clock edge.
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin errors++; \
  $display("ERROR %s exp %h got %h", n, e, s); end end
module timer0_shared_prescaler_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       i_sys_clk = 1'b0;
  logic       i_rst = 1'b1;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata, d, e_m;
  logic       i_wr = 1'b0, i_rd = 1'b0, rd_q = 1'b0;
  logic       i_timer_ext_count_pin, i_watchdog_clear_instr = 1'b0;
  logic       i_watchdog_base_tick = 1'b0, o_watchdog_tick;
  logic       o_watchdog_clear, o_irq, go = 1'b0, busy;
  logic [3:0] half = 4'h2;
  logic [7:0] exp_q[$];  // Expected read data, oldest first
  logic [7:0] cfg[4] = '{8'h20, 8'h30, 8'h21, 8'h28};
  logic [7:0] cnt[4] = '{8'h04, 8'h04, 8'h02, 8'h08};
  int         errors = 0, n_tests = 0, wd_n = 0, k;
  always #5 i_sys_clk = ~i_sys_clk;
  timer0_shared_prescaler i_timer0_shared_prescaler (.i_sys_clk, .i_rst,
    .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_timer_ext_count_pin,
    .i_watchdog_clear_instr, .i_watchdog_base_tick, .o_watchdog_tick,
    .o_watchdog_clear, .o_irq);
  ext_count_source i_ext_count_source (.i_sys_clk, .i_start(go),
    .i_pulses(8'h08), .i_half(half), .o_pin(i_timer_ext_count_pin),
    .o_busy(busy));
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    i_rd <= 1'b0;
    @(posedge i_sys_clk);
  endtask
  // Strobes stay up between back-to-back calls; idle drops them
  task automatic idle;
    i_wr <= 1'b0;
    i_rd <= 1'b0;
  endtask
  // Notes the expectation, the monitor compares it a cycle later
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_addr <= a;
    i_rd <= 1'b1;
    i_wr <= 1'b0;
    @(posedge i_sys_clk);
  endtask
  task automatic end_of_test;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Read data stands only in the cycle after the strobe
  always @(posedge i_sys_clk) begin
    if (rd_q) begin
      e_m = exp_q.pop_front();
      `CHK("rdata", e_m, o_rdata)
    end
    if (o_watchdog_tick === 1'b1) wd_n++;
    rd_q <= i_rd;
  end
  initial begin
    void'($urandom(23));
    repeat (20) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    rd(8'h81, 8'hff);
    rd(8'h02, 8'h00);
    // Pin counting per owner, ratio and edge; random start and pace
    foreach (cfg[i]) begin
      d = 8'($urandom_range(240));
      wr(8'h81, cfg[i]);
      wr(8'h01, d);
      rd(8'h81, cfg[i]);
      idle();
      repeat (10) @(posedge i_sys_clk);
      half <= 4'($urandom_range(5, 2));
      go <= 1'b1;
      @(posedge i_sys_clk);
      go <= 1'b0;
      @(posedge i_sys_clk);
      for (k = 0; k < 500 && busy !== 1'b0; k++) begin
        @(posedge i_sys_clk);
        i_watchdog_base_tick <= 1'($urandom);
      end
      i_watchdog_base_tick <= 1'b0;
      if (k == 500) begin
        errors++;
        end_of_test();
      end
      repeat (8) @(posedge i_sys_clk);
      rd(8'h01, d + cnt[i]);
    end
    // Instruction-cycle counting up to a wrap
    wr(8'h81, 8'h08);
    wr(8'h01, 8'hfe);
    rd(8'h01, 8'hfe);
    idle();
    repeat (24) @(posedge i_sys_clk);
    rd(8'h0b, 8'h04);
    wr(8'h91, 8'h01);
    #1 `CHK("irq set", 1'b1, o_irq)
    wr(8'h90, 8'h01);
    wr(8'h0b, 8'h00);
    rd(8'h0b, 8'h00);
    #1 `CHK("irq clear", 1'b0, o_irq)
    // Clear the prescaler before the owner moves
    wr(8'h81, 8'h20);
    wr(8'h01, 8'h00);
    for (int r = 0; r < 3; r++) begin
      wr(8'h81, 8'h08 | 8'(r));
      idle();
      i_watchdog_clear_instr <= 1'b1;
      @(posedge i_sys_clk);
      i_watchdog_clear_instr <= 1'b0;
      @(posedge i_sys_clk);
      wd_n = 0;
      repeat (9) begin
        i_watchdog_base_tick <= 1'b1;
        @(posedge i_sys_clk);
        i_watchdog_base_tick <= 1'b0;
        @(posedge i_sys_clk);
      end
      `CHK("wdt ticks", 9 >> r, wd_n)
    end
    end_of_test();
  end
endmodule
bind timer0_shared_prescaler timer0_chk i_timer0_chk (.i_sys_clk, .i_rst,
  .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_watchdog_clear_instr,
  .i_watchdog_base_tick, .o_watchdog_tick, .o_watchdog_clear);
`undef CHK
`default_nettype wire
